/* File: rtl/supervisor_pkg.sv */
// constants and types for the supervisory reset and watchdog block
// How it works
// - no kick for 1.6 s asserts reset
// - either edge on kick restarts count
// - optionally watch serial data instead
// - low supply holds both resets active
// - reset held 200 ms after supply returns
// - manual low asserts, plus one timeout after
// - manual input debounced, idles high
// - external low on reset pin starts reset
// - outputs open drain, drive asserted only
// - write protect high blocks all writes
// - low supply inhibits all memory writes
package supervisor_pkg;
  localparam int CLOCK_MHZ = 200;
  localparam int WATCHDOG_MS = 1600;
  localparam int TIMEOUT_MS = 200;
  localparam int DEBOUNCE_US = 1000;
  localparam int CYCLES_PER_MS = CLOCK_MHZ * 1000;
  localparam int WATCHDOG_CYCLES = WATCHDOG_MS * CYCLES_PER_MS;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CYCLES_PER_MS;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLOCK_MHZ;
  localparam logic RESET_LEVEL_IDLE = 1'b0;

  typedef enum logic [1:0] {RUN, HOLD} sup_state_t;

  // open-drain pin: output value and active-low enable
  typedef struct packed {
    logic level;
    logic enable_n;
  } od_pin_t;
endpackage : supervisor_pkg

/* File: rtl/supervisor_reset_watchdog.sv */
// supervisory reset, watchdog, manual reset and write gating
`timescale 1ns/100ps
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter int WATCHDOG_LIMIT = WATCHDOG_CYCLES,
  parameter int TIMEOUT_LIMIT = TIMEOUT_CYCLES,
  parameter int DEBOUNCE_LIMIT = DEBOUNCE_CYCLES,
  parameter bit WATCH_SERIAL = 1'b0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic supplyLow,
  input wire logic manual_reset_in,
  input wire logic watchdog_kick_in,
  input wire logic serialDataIn,
  input wire logic resetPinIn,
  input wire logic writeProtect,
  input wire logic writeRequest,
  output od_pin_t resetLowPin,
  output od_pin_t resetHighPin,
  output logic resetActive,
  output logic writeAllowed
);
  localparam int CW = 32;

  initial begin
    if (WATCHDOG_LIMIT < 2 || TIMEOUT_LIMIT < 2 || DEBOUNCE_LIMIT < 1) begin
      $error("supervisor: counts too small");
    end
  end

  sup_state_t state;
  logic [CW-1:0] holdCount;
  logic [CW-1:0] dogCount;
  logic [CW-1:0] bounceCount;
  logic manualClean;
  logic manualLast;
  logic kickLast;
  logic kickSeen;
  logic kickSrc;
  logic dogExpire;
  logic holdCause;
  logic pinPulled;
  logic busyHold;

  assign kickSrc = WATCH_SERIAL ? serialDataIn : watchdog_kick_in;
  assign kickSeen = kickSrc != kickLast;
  assign dogExpire = dogCount >= CW'(WATCHDOG_LIMIT - 1);
  // external low seen only when we are not driving it ourselves
  // own drive lags state by one cycle through resetActive
  assign pinPulled = !resetPinIn && !resetActive && state == RUN;
  assign holdCause = supplyLow || !manualClean || pinPulled;

  // debounce: accept a level once it stays stable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      manualClean <= 1'b1;
      manualLast <= 1'b1;
      bounceCount <= '0;
    end else begin
      manualLast <= manual_reset_in;
      if (manual_reset_in != manualLast || manual_reset_in == manualClean) begin
        bounceCount <= '0;
      end else if (bounceCount >= CW'(DEBOUNCE_LIMIT - 1)) begin
        manualClean <= manual_reset_in;
        bounceCount <= '0;
      end else begin
        bounceCount <= bounceCount + CW'(1);
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      kickLast <= 1'b0;
    end else begin
      kickLast <= kickSrc;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dogCount <= '0;
    end else if (state != RUN || kickSeen) begin
      dogCount <= '0;
    end else if (!dogExpire) begin
      dogCount <= dogCount + CW'(1);
    end
  end

  // reset starts held as after power-up
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= HOLD;
      holdCount <= '0;
    end else begin
      case (state)
        RUN: begin
          if (holdCause || dogExpire) begin
            state <= HOLD;
            holdCount <= '0;
          end
        end
        HOLD: begin
          if (holdCause) begin
            holdCount <= '0;
          end else if (holdCount >= CW'(TIMEOUT_LIMIT - 1)) begin
            state <= RUN;
            holdCount <= '0;
          end else begin
            holdCount <= holdCount + CW'(1);
          end
        end
        default: begin
          state <= HOLD;
          holdCount <= '0;
        end
      endcase
    end
  end

  assign busyHold = state == HOLD;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      resetActive <= 1'b1;
    end else begin
      resetActive <= busyHold;
    end
  end

  // drive only toward the asserted level, else release
  assign resetLowPin.level = 1'b0;
  assign resetLowPin.enable_n = !resetActive;
  assign resetHighPin.level = 1'b1;
  assign resetHighPin.enable_n = !resetActive;

  assign writeAllowed = writeRequest && !writeProtect && !supplyLow
    && !(busyHold && holdCount == '0 && supplyLow);

  chk_low_supply_holds: assert property (@(posedge clock) disable iff (rst)
    supplyLow |=> ##1 resetActive)
    else $error("reset not held under low supply");
  chk_timeout_length: assert property (@(posedge clock) disable iff (rst)
    $fell(supplyLow) && !manual_reset_in == 1'b0 |=> resetActive[*8])
    else $error("reset released too early");
  chk_write_protect: assert property (@(posedge clock) disable iff (rst)
    writeProtect |-> !writeAllowed)
    else $error("write passed under protect");
  chk_write_supply: assert property (@(posedge clock) disable iff (rst)
    supplyLow |-> !writeAllowed)
    else $error("write passed under low supply");
  chk_dog_fires: assert property (@(posedge clock) disable iff (rst)
    state == RUN && dogExpire && !kickSeen |=> state == HOLD)
    else $error("watchdog expiry ignored");
  chk_kick_restart: assert property (@(posedge clock) disable iff (rst)
    kickSeen |=> dogCount == '0)
    else $error("kick did not restart count");
  chk_manual_holds: assert property (@(posedge clock) disable iff (rst)
    !manualClean |=> ##1 resetActive)
    else $error("manual reset not held");
  chk_pin_input: assert property (@(posedge clock) disable iff (rst)
    pinPulled |=> state == HOLD)
    else $error("external reset ignored");
  chk_open_drain: assert property (@(posedge clock) disable iff (rst)
    resetLowPin.enable_n == resetHighPin.enable_n
    && resetLowPin.enable_n == !resetActive)
    else $error("open drain enables wrong");
  chk_debounce_idle: assert property (@(posedge clock) disable iff (rst)
    manual_reset_in && $past(manual_reset_in) && manualClean |=> manualClean)
    else $error("manual input glitched low");
  chk_dog_restart: assert property (@(posedge clock) disable iff (rst)
    $fell(busyHold) |-> dogCount == '0)
    else $error("count not fresh after release");

  chk_own_drive: assert property (@(posedge clock) disable iff (rst)
    $fell(busyHold) && !supplyLow && manualClean |=> !busyHold)
    else $error("own reset drive taken as new cause");
  chk_cause_holds: assert property (@(posedge clock) disable iff (rst)
    busyHold && holdCause |=> busyHold)
    else $error("reset released while cause present");
  chk_release_count: assert property (@(posedge clock) disable iff (rst)
    $fell(busyHold) |-> $past(holdCount) == CW'(TIMEOUT_LIMIT - 1))
    else $error("reset released after wrong count");
  chk_hold_bound: assert property (@(posedge clock) disable iff (rst)
    holdCount <= CW'(TIMEOUT_LIMIT - 1))
    else $error("hold count overran");
  chk_dog_held: assert property (@(posedge clock) disable iff (rst)
    busyHold |=> dogCount == '0)
    else $error("watchdog counted during reset");
  chk_dog_bound: assert property (@(posedge clock) disable iff (rst)
    dogCount <= CW'(WATCHDOG_LIMIT - 1))
    else $error("watchdog count overran");
  chk_bounce_bound: assert property (@(posedge clock) disable iff (rst)
    bounceCount <= CW'(DEBOUNCE_LIMIT - 1))
    else $error("debounce count overran");
  chk_pin_levels: assert property (@(posedge clock) disable iff (rst)
    resetLowPin.level == 1'b0 && resetHighPin.level == 1'b1)
    else $error("open drain level wrong");
  chk_write_idle: assert property (@(posedge clock) disable iff (rst)
    !writeRequest |-> !writeAllowed)
    else $error("write passed with no request");
  chk_write_open: assert property (@(posedge clock) disable iff (rst)
    writeRequest && !writeProtect && !supplyLow |-> writeAllowed)
    else $error("legal write blocked");


  cov_dog_reset: cover property (@(posedge clock) disable iff (rst)
    state == RUN && dogExpire);
  cov_manual_reset: cover property (@(posedge clock) disable iff (rst)
    $fell(manualClean));
  cov_release: cover property (@(posedge clock) disable iff (rst)
    $fell(resetActive));
  cov_pin_reset: cover property (@(posedge clock) disable iff (rst)
    pinPulled);
  cov_kick_restart: cover property (@(posedge clock) disable iff (rst)
    state == RUN && kickSeen);
endmodule : supervisor_reset_watchdog

/* File: tb/mcu_partner.sv */
// microcontroller model: reset wire pull-up and watchdog kicks
`timescale 1ns/100ps
module mcu_partner
  import supervisor_pkg::*;
(
  input wire logic clock,
  input wire od_pin_t resetLowPin,
  input wire logic kickOn,
  input wire logic forceLow,
  output logic kick,
  output logic resetWire
);
  logic [3:0] tick = 4'h0;
  // pulled up unless either side pulls low
  assign resetWire = !(resetLowPin.enable_n == 1'b0 || forceLow);
  initial kick = 1'b0;
  always @(posedge clock) begin
    tick <= (tick == 4'h9) ? 4'h0 : tick + 4'h1;
    if (kickOn && tick == 4'h9) kick <= #1 !kick;
  end
endmodule : mcu_partner

/* File: tb/supervisor_reset_watchdog_bench.sv */
// bench for the supervisory reset and watchdog block
`timescale 1ns/100ps
module supervisor_reset_watchdog_bench;
  import supervisor_pkg::*;
  localparam int WD = 50;
  localparam int TO = 20;
  localparam int DB = 4;
  logic clock, rst, supplyLow, manualIn, writeProtect, writeRequest;
  logic kickOn, forceLow, kick, resetWire, resetActive, writeAllowed;
  od_pin_t resetLowPin, resetHighPin;
  logic serialActive;
  int n_mismatch = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  supervisor_reset_watchdog #(.WATCHDOG_LIMIT(WD), .TIMEOUT_LIMIT(TO),
    .DEBOUNCE_LIMIT(DB)) dut (.clock(clock), .rst(rst),
    .supplyLow(supplyLow), .manual_reset_in(manualIn),
    .watchdog_kick_in(kick), .serialDataIn(kick), .resetPinIn(resetWire),
    .writeProtect(writeProtect), .writeRequest(writeRequest),
    .resetLowPin(resetLowPin), .resetHighPin(resetHighPin),
    .resetActive(resetActive), .writeAllowed(writeAllowed));
  supervisor_reset_watchdog #(.WATCHDOG_LIMIT(WD), .TIMEOUT_LIMIT(TO),
    .DEBOUNCE_LIMIT(DB), .WATCH_SERIAL(1'b1)) dutSerial (.clock(clock),
    .rst(rst), .supplyLow(supplyLow), .manual_reset_in(manualIn),
    .watchdog_kick_in(1'b0), .serialDataIn(kick), .resetPinIn(1'b1),
    .writeProtect(writeProtect), .writeRequest(writeRequest),
    .resetLowPin(), .resetHighPin(), .resetActive(serialActive),
    .writeAllowed());
  mcu_partner mcu (.clock(clock), .resetLowPin(resetLowPin),
    .kickOn(kickOn), .forceLow(forceLow), .kick(kick),
    .resetWire(resetWire));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic step(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task automatic waitFor(logic lvl, output int k);
    k = 0;
    while (resetActive !== lvl && k < 1000) begin
      step(1);
      k++;
    end
  endtask : waitFor
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic t_supply;
    supplyLow = 1'b1;
    writeRequest = 1'b1;
    step(2);
    check("lowPin", resetLowPin, 2'b00);
    check("highPin", resetHighPin, 2'b10);
    check("writeLow", writeAllowed, 1'b0);
    step(TO * 2);
    check("active", resetActive, 1'b1);
    supplyLow = 1'b0;
    waitFor(1'b0, n);
    check("holdLen", n, TO + 1);
    check("released", {resetLowPin.enable_n, resetHighPin.enable_n}, 2'h3);
    check("writeOk", writeAllowed, 1'b1);
    writeProtect = 1'b1;
    step(1);
    check("protect", writeAllowed, 1'b0);
    writeProtect = 1'b0;
    $display("test supply done");
  endtask : t_supply
  task automatic t_watchdog;
    step(WD * 3);
    check("kicked", resetActive, 1'b0);
    check("serialKick", serialActive, 1'b0);
    kickOn = 1'b0;
    waitFor(1'b1, n);
    check("expiry", n inside {[WD - 10:WD + 3]}, 1'b1);
    check("serialExpiry", serialActive, 1'b1);
    waitFor(1'b0, n);
    check("wdHold", n inside {[TO:TO + 2]}, 1'b1);
    step(WD - 5);
    check("fresh", resetActive, 1'b0);
    waitFor(1'b1, n);
    check("again", n inside {[4:6]}, 1'b1);
    kickOn = 1'b1;
    waitFor(1'b0, n);
    check("wdHold2", n inside {[TO:TO + 2]}, 1'b1);
    $display("test watchdog done");
  endtask : t_watchdog
  task automatic t_manual;
    manualIn = 1'b0;
    step(DB - 2);
    manualIn = 1'b1;
    step(10);
    check("glitch", resetActive, 1'b0);
    manualIn = 1'b0;
    step(TO * 2);
    check("manual", resetActive, 1'b1);
    manualIn = 1'b1;
    waitFor(1'b0, n);
    check("manHold", n inside {[TO + 1:TO + DB + 3]}, 1'b1);
    forceLow = 1'b1;
    step(3);
    forceLow = 1'b0;
    step(1);
    check("wire", {resetActive, resetWire}, 2'h2);
    waitFor(1'b0, n);
    check("wireHold", n inside {[TO - 4:TO + 2]}, 1'b1);
    $display("test manual and wire done");
  endtask : t_manual
  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      test_done;
    end
  end
  initial begin
    {rst, manualIn, kickOn} = 3'h7;
    {supplyLow, writeProtect, writeRequest, forceLow} = 4'h0;
    step(12);
    rst = 1'b0;
    waitFor(1'b0, n);
    check("porHold", n, TO + 1);
    t_supply;
    t_watchdog;
    t_manual;
    test_done;
  end
endmodule : supervisor_reset_watchdog_bench
